// ==== logic/eep_pkg.sv ====
// Shared constants and types for both ends of the serial EEPROM link
package eep_pkg;
  // Device type codes in the upper nibble of the device address byte
  localparam logic [3:0] EEP_MEM_TYPE   = 4'hA;
  localparam logic [3:0] EEP_ID_TYPE    = 4'hB;
  // Array and identification page sizes
  localparam int         EEP_MEM_BYTES  = 65536;
  localparam int         EEP_ID_BYTES   = 128;
  // Position of the id area select bit inside the high address byte
  localparam int         EEP_ID_AREA_POS = 2;
  // Bit slot holding the acknowledge within a nine-clock frame
  localparam logic [3:0] EEP_ACK_SLOT   = 4'h8;
  // Data byte sent by the lock-state query
  localparam logic [7:0] EEP_QUERY_BYTE = 8'h00;
  // Host timing: one quarter of an SCL period
  localparam int         EEP_CLK_NS     = 40;
  localparam int         EEP_QTR_NS     = 160;
  localparam int         EEP_QTR_CYC    = (EEP_QTR_NS + EEP_CLK_NS - 1) / EEP_CLK_NS;
  // Quarter ticks of SCL run after reset; the slave's reset path moves only on SCL edges
  localparam logic [3:0] EEP_FLUSH_TICKS = 4'hF;

  // Device receiver states
  typedef enum logic [2:0] {
    DS_IDLE    = 3'b000,
    DS_DEVADDR = 3'b001,
    DS_ADDR_HI = 3'b010,
    DS_ADDR_LO = 3'b011,
    DS_WDATA   = 3'b100,
    DS_RDATA   = 3'b101
  } eep_dst_type;

  // Host bit-level states
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_START = 3'b001,
    HS_TX    = 3'b010,
    HS_RX    = 3'b011,
    HS_STOP  = 3'b100
  } eep_hst_type;

  // Host operations
  typedef enum logic [1:0] {
    OP_CUR_READ   = 2'b00,
    OP_RAND_READ  = 2'b01,
    OP_ID_READ    = 2'b10,
    OP_LOCK_QUERY = 2'b11
  } eep_op_type;

  // Host transaction steps
  localparam logic [2:0] STEP_DEVW    = 3'h0;
  localparam logic [2:0] STEP_HI      = 3'h1;
  localparam logic [2:0] STEP_LO      = 3'h2;
  localparam logic [2:0] STEP_RESTART = 3'h3;
  localparam logic [2:0] STEP_DEVR    = 3'h4;
  localparam logic [2:0] STEP_RX      = 3'h5;
  localparam logic [2:0] STEP_DATA    = 3'h7;
endpackage : eep_pkg

// ==== logic/eep_link_if.sv ====
// Two-wire link between bus master and EEPROM slave
`timescale 1ns/1ps
interface eep_link_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic sda;

  // Open-drain wire with pull-up
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport dev (input scl, input sda, output sda_dev_oe);
  modport host (output scl, output sda_host_oe, input sda);
endinterface : eep_link_if

// ==== logic/eep_dev_end.sv ====
// EEPROM slave read side, clocked by the link clock
`timescale 1ns/1ps
module eep_dev_end
  import eep_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       LOAD_EN,
  input  wire logic       LOAD_ID,
  input  wire logic [15:0] LOAD_ADDR,
  input  wire logic [7:0] LOAD_DATA,
  input  wire logic       CHIP_SELECT_PIN_2,
  input  wire logic       CHIP_SELECT_PIN_1,
  input  wire logic       CHIP_SELECT_PIN_0,
  input  wire logic       ID_LOCKED,
  eep_link_if.dev         LINK
);

  logic [7:0]  mem_array [0:EEP_MEM_BYTES-1];
  logic [7:0]  id_array  [0:EEP_ID_BYTES-1];
  logic [4:0]  pin_raw;
  logic [4:0]  pin_s1_q;
  logic [4:0]  pin_s2_q;
  logic [4:0]  pin_s3_q;
  logic [4:0]  pin_q;
  logic        link_rst;
  logic        id_locked;
  logic [2:0]  chip_sel;
  logic        start_tog_q;
  logic        start_seen_q;
  logic        stop_tog_q;
  logic        stop_seen_q;
  eep_dst_type state_q;
  logic [3:0]  bit_q;
  logic [6:0]  shreg_q;
  logic [7:0]  rx_byte;
  logic        ack_q;
  logic        id_sel_q;
  logic [7:0]  addr_hi_q;
  logic [15:0] addr_q;
  logic [7:0]  rd_byte_q;
  logic        sda_oe_q;

  // Preload port; the array has no write path from the link
  always_ff @(posedge SYS_CLK) begin
    if (LOAD_EN) begin
      if (LOAD_ID) begin
        id_array[LOAD_ADDR[6:0]] <= LOAD_DATA;
      end else begin
        mem_array[LOAD_ADDR] <= LOAD_DATA;
      end
    end
  end

  // Pins and reset arrive from outside the link domain
  assign pin_raw = {SYS_RST, ID_LOCKED, CHIP_SELECT_PIN_2, CHIP_SELECT_PIN_1, CHIP_SELECT_PIN_0};

  // Three-stage synchronisers, change taken when stages agree
  always_ff @(posedge LINK.scl) begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      // Filtered level per pin
      always_ff @(posedge LINK.scl) begin
        if (pin_s2_q[gi] == pin_s3_q[gi]) begin
          pin_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  assign link_rst  = pin_q[4];
  assign id_locked = pin_q[3];
  assign chip_sel  = pin_q[2:0];

  // Start: SDA falls while SCL is high
  always_ff @(negedge LINK.sda) begin
    if (link_rst) begin
      start_tog_q <= 1'b0;
    end else if (LINK.scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // Stop: SDA rises while SCL is high
  always_ff @(posedge LINK.sda) begin
    if (link_rst) begin
      stop_tog_q <= 1'b0;
    end else if (LINK.scl) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // Byte assembled at the eighth rising edge
  assign rx_byte = {shreg_q, LINK.sda};

  // Read source picked by target area and counter
  function automatic logic [7:0] rd_pick(input logic id, input logic [15:0] a);
    rd_pick = id ? id_array[a[6:0]] : mem_array[a];
  endfunction : rd_pick

  // Receiver, sampled on the rising SCL edge
  always_ff @(posedge LINK.scl) begin
    if (link_rst) begin
      state_q      <= DS_IDLE;
      bit_q        <= 4'h0;
      shreg_q      <= 7'h00;
      ack_q        <= 1'b0;
      id_sel_q     <= 1'b0;
      addr_hi_q    <= 8'h00;
      addr_q       <= 16'h0000;
      rd_byte_q    <= 8'hFF;
      start_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else if (start_tog_q != start_seen_q) begin
      // First address bit rides the first edge after a start
      start_seen_q <= start_tog_q;
      stop_seen_q  <= stop_tog_q;
      state_q      <= DS_DEVADDR;
      shreg_q      <= {6'h00, LINK.sda};
      bit_q        <= 4'h1;
      ack_q        <= 1'b0;
    end else if (stop_tog_q != stop_seen_q) begin
      // Standby after a stop; taken on the SCL rise the host makes before its next start
      stop_seen_q <= stop_tog_q;
      state_q     <= DS_IDLE;
      bit_q       <= 4'h0;
      ack_q       <= 1'b0;
    end else if (bit_q == EEP_ACK_SLOT) begin
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      // Master acknowledge slot after a data byte
      if (state_q == DS_RDATA && !ack_q) begin
        if (!LINK.sda) begin
          rd_byte_q <= rd_pick(id_sel_q, addr_q);
          addr_q    <= addr_q + 16'h0001;
        end else begin
          state_q <= DS_IDLE;
        end
      end
    end else begin
      shreg_q <= rx_byte[6:0];
      bit_q   <= bit_q + 4'h1;
      if (bit_q == 4'h7) begin
        case (state_q)
          DS_DEVADDR: begin
            // Type code and chip select must both match
            if ((rx_byte[7:4] == EEP_MEM_TYPE || rx_byte[7:4] == EEP_ID_TYPE) &&
                rx_byte[3:1] == chip_sel) begin
              ack_q    <= 1'b1;
              id_sel_q <= (rx_byte[7:4] == EEP_ID_TYPE);
              if (rx_byte[0]) begin
                state_q   <= DS_RDATA;
                rd_byte_q <= rd_pick(rx_byte[7:4] == EEP_ID_TYPE, addr_q);
                addr_q    <= addr_q + 16'h0001;
              end else begin
                state_q <= DS_ADDR_HI;
              end
            end else begin
              state_q <= DS_IDLE;
            end
          end
          DS_ADDR_HI: begin
            addr_hi_q <= rx_byte;
            ack_q     <= 1'b1;
            state_q   <= DS_ADDR_LO;
          end
          DS_ADDR_LO: begin
            // Id page keeps only the low seven bits as offset
            if (id_sel_q) begin
              addr_q <= {9'h000, rx_byte[6:0]};
            end else begin
              addr_q <= {addr_hi_q, rx_byte};
            end
            ack_q   <= 1'b1;
            state_q <= DS_WDATA;
          end
          DS_WDATA: begin
            // Data not stored: writes are outside this block
            ack_q  <= !(id_sel_q && id_locked);
            addr_q <= addr_q + 16'h0001;
          end
          default: begin
            ack_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Driver, updated on the falling SCL edge only
  always_ff @(negedge LINK.scl) begin
    if (link_rst) begin
      sda_oe_q <= 1'b0;
    end else if (bit_q == EEP_ACK_SLOT) begin
      sda_oe_q <= ack_q;
    end else if (state_q == DS_RDATA) begin
      sda_oe_q <= ~rd_byte_q[3'h7 - bit_q[2:0]];
    end else begin
      sda_oe_q <= 1'b0;
    end
  end

  // Open drain: only ever pulls low
  assign LINK.sda_dev_oe = sda_oe_q;

endmodule : eep_dev_end

// ==== logic/eep_host_end.sv ====
// Two-wire bus master issuing reads and the lock query
`timescale 1ns/1ps
module eep_host_end
  import eep_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire eep_op_type  CMD_OP,
  input  wire logic [2:0]  CMD_CS,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_COUNT,
  output logic             RD_VALID,
  output logic [7:0]       RD_DATA,
  output logic             DONE,
  output logic             ADDR_NACK,
  output logic             ID_LOCKED_SEEN,
  eep_link_if.host         LINK
);

  eep_hst_type st_q;
  eep_op_type  op_q;
  logic [2:0]  tcnt_q;
  logic        tick;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [2:0]  step_q;
  logic [7:0]  txb_q;
  logic [7:0]  rxb_q;
  logic [7:0]  cnt_q;
  logic [2:0]  cs_q;
  logic [15:0] addr_q;
  logic        ackbit_q;
  logic        scl_q;
  logic        sda_oe_q;
  logic        sda_s1_q;
  logic        sda_s2_q;
  logic        sda_s3_q;
  logic        sda_q;
  logic [7:0]  rd_data_q;
  logic        rd_valid_q;
  logic        done_q;
  logic        nack_q;
  logic        locked_q;
  logic [3:0]  flush_q;

  // SDA comes back from the link domain
  always_ff @(posedge SYS_CLK) begin
    sda_s1_q <= LINK.sda;
    sda_s2_q <= sda_s1_q;
    sda_s3_q <= sda_s2_q;
    if (sda_s2_q == sda_s3_q) begin
      sda_q <= sda_s3_q;
    end
  end

  // Quarter-period tick for the SCL divider
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || (st_q == HS_IDLE && flush_q == 4'h0) || tick) begin
      tcnt_q <= 3'h0;
    end else begin
      tcnt_q <= tcnt_q + 3'h1;
    end
  end
  assign tick = (tcnt_q == 3'(EEP_QTR_CYC - 1));

  // Byte to send for a given step
  function automatic logic [7:0] tx_pick(input logic [2:0] s);
    logic [3:0] ty;
    logic [7:0] hi;
    ty = (op_q == OP_CUR_READ || op_q == OP_RAND_READ) ? EEP_MEM_TYPE : EEP_ID_TYPE;
    hi = addr_q[15:8];
    if (ty == EEP_ID_TYPE) begin
      hi[EEP_ID_AREA_POS] = 1'b0;
    end
    case (s)
      STEP_DEVW: tx_pick = {ty, cs_q, 1'b0};
      STEP_HI:   tx_pick = hi;
      STEP_LO:   tx_pick = addr_q[7:0];
      STEP_DEVR: tx_pick = {ty, cs_q, 1'b1};
      default:   tx_pick = EEP_QUERY_BYTE;
    endcase
  endfunction : tx_pick

  // Transaction sequencer; SCL keeps running in reset so the slave resets
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_q       <= HS_IDLE;
      // Unknown power-up level takes the else arm, so the toggle always starts
      if (scl_q) begin
        scl_q <= 1'b0;
      end else begin
        scl_q <= 1'b1;
      end
      // SDA follows SCL so the slave's start and stop flops see edges in reset
      sda_oe_q   <= scl_q;
      flush_q    <= EEP_FLUSH_TICKS;
      ph_q       <= 2'h0;
      bit_q      <= 4'h0;
      step_q     <= STEP_DEVW;
      op_q       <= OP_CUR_READ;
      txb_q      <= 8'h00;
      rxb_q      <= 8'h00;
      cnt_q      <= 8'h00;
      cs_q       <= 3'h0;
      addr_q     <= 16'h0000;
      ackbit_q   <= 1'b1;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      done_q     <= 1'b0;
      nack_q     <= 1'b0;
      locked_q   <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      done_q     <= 1'b0;
      if (flush_q != 4'h0) begin
        // Keep clocking until the slave's synchronised reset has dropped; ends with SCL high
        sda_oe_q <= 1'b0;
        if (tick) begin
          scl_q   <= flush_q[0];
          flush_q <= flush_q - 4'h1;
        end
      end else if (st_q == HS_IDLE) begin
        scl_q    <= 1'b1;
        sda_oe_q <= 1'b0;
        ph_q     <= 2'h0;
        if (CMD_VALID) begin
          op_q   <= CMD_OP;
          cs_q   <= CMD_CS;
          addr_q <= CMD_ADDR;
          if (CMD_OP == OP_ID_READ && {1'b0, CMD_COUNT} > 9'(EEP_ID_BYTES) - {2'b00, CMD_ADDR[6:0]}) begin
            // Clip the count at the page end
            cnt_q <= 8'(EEP_ID_BYTES) - {1'b0, CMD_ADDR[6:0]};
          end else begin
            cnt_q <= (CMD_COUNT == 8'h00) ? 8'h01 : CMD_COUNT;
          end
          nack_q <= 1'b0;
          // Current read skips the dummy write
          step_q <= (CMD_OP == OP_CUR_READ) ? STEP_DEVR : STEP_DEVW;
          st_q   <= HS_START;
        end
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (st_q)
          HS_START: begin
            case (ph_q)
              2'h0: begin
                scl_q    <= 1'b0;
                sda_oe_q <= 1'b0;
              end
              2'h1: scl_q <= 1'b1;
              2'h2: sda_oe_q <= 1'b1;
              default: begin
                scl_q <= 1'b0;
                txb_q <= tx_pick(step_q);
                bit_q <= 4'h0;
                st_q  <= HS_TX;
              end
            endcase
          end
          HS_TX: begin
            case (ph_q)
              2'h0: sda_oe_q <= (bit_q == EEP_ACK_SLOT) ? 1'b0 : ~txb_q[7];
              2'h1: scl_q <= 1'b1;
              2'h2: ackbit_q <= sda_q;
              default: begin
                scl_q <= 1'b0;
                if (bit_q != EEP_ACK_SLOT) begin
                  txb_q <= {txb_q[6:0], 1'b0};
                  bit_q <= bit_q + 4'h1;
                end else if (step_q == STEP_DATA) begin
                  locked_q <= ackbit_q;
                  st_q     <= HS_STOP;
                end else if (ackbit_q) begin
                  nack_q <= 1'b1;
                  st_q   <= HS_STOP;
                end else if (step_q == STEP_LO && op_q != OP_LOCK_QUERY) begin
                  step_q <= STEP_DEVR;
                  st_q   <= HS_START;
                end else if (step_q == STEP_DEVR) begin
                  step_q <= STEP_RX;
                  bit_q  <= 4'h0;
                  st_q   <= HS_RX;
                end else begin
                  step_q <= (step_q == STEP_LO) ? STEP_DATA : step_q + 3'h1;
                  txb_q  <= tx_pick((step_q == STEP_LO) ? STEP_DATA : step_q + 3'h1);
                  bit_q  <= 4'h0;
                end
              end
            endcase
          end
          HS_RX: begin
            case (ph_q)
              // Ack every byte but the last
              2'h0: sda_oe_q <= (bit_q == EEP_ACK_SLOT) && (cnt_q != 8'h01);
              2'h1: scl_q <= 1'b1;
              2'h2: if (bit_q != EEP_ACK_SLOT) rxb_q <= {rxb_q[6:0], sda_q};
              default: begin
                scl_q <= 1'b0;
                if (bit_q == 4'h7) begin
                  rd_data_q  <= rxb_q;
                  rd_valid_q <= 1'b1;
                end
                if (bit_q != EEP_ACK_SLOT) begin
                  bit_q <= bit_q + 4'h1;
                end else if (cnt_q == 8'h01) begin
                  st_q <= HS_STOP;
                end else begin
                  cnt_q <= cnt_q - 8'h01;
                  bit_q <= 4'h0;
                end
              end
            endcase
          end
          HS_STOP: begin
            case (ph_q)
              2'h0: begin
                scl_q    <= 1'b0;
                sda_oe_q <= 1'b1;
              end
              2'h1: scl_q <= 1'b1;
              2'h2: sda_oe_q <= 1'b0;
              default: begin
                done_q <= 1'b1;
                st_q   <= HS_IDLE;
              end
            endcase
          end
          default: st_q <= HS_IDLE;
        endcase
      end
    end
  end

  // Outputs
  assign CMD_READY        = (st_q == HS_IDLE) && !SYS_RST && (flush_q == 4'h0);
  assign RD_VALID         = rd_valid_q;
  assign RD_DATA          = rd_data_q;
  assign DONE             = done_q;
  assign ADDR_NACK        = nack_q;
  assign ID_LOCKED_SEEN   = locked_q;
  assign LINK.scl         = scl_q;
  assign LINK.sda_host_oe = sda_oe_q;

endmodule : eep_host_end

// ==== testbench/eep_link_monitor.sv ====
// Wire-level checker for the two-wire EEPROM link
`timescale 1ns/1ps
module eep_link_monitor
  import eep_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic scl,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda,
  input wire logic CHIP_SELECT_PIN_2,
  input wire logic CHIP_SELECT_PIN_1,
  input wire logic CHIP_SELECT_PIN_0,
  input wire logic ID_LOCKED
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] slot_q;
  logic [7:0] frame_q;
  logic [7:0] addr_q;
  logic       rd_q;
  logic       rise;
  logic       fall;
  logic       start;
  logic       cs_ok;
  logic       ack_rise;

  // Wire edges seen by oversampling on the system clock
  assign rise     = scl & ~scl_q;
  assign fall     = ~scl & scl_q;
  assign start    = scl & scl_q & sda_q & ~sda;
  assign cs_ok    = addr_q[3:1] == {CHIP_SELECT_PIN_2, CHIP_SELECT_PIN_1, CHIP_SELECT_PIN_0};
  assign ack_rise = rise & (slot_q == EEP_ACK_SLOT);

  default clocking mon_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  // Previous wire levels
  always_ff @(posedge SYS_CLK) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // Slot parks before bit 0 on a start, so the start's own fall lands on 0
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || start) begin
      slot_q  <= 4'hF;
      frame_q <= 8'h00;
    end else if (fall) begin
      slot_q  <= (slot_q == EEP_ACK_SLOT) ? 4'h0 : slot_q + 4'h1;
      frame_q <= (slot_q == EEP_ACK_SLOT) ? frame_q + 8'h01 : frame_q;
    end
  end

  // Device address byte and direction of the frame in progress
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      addr_q <= 8'h00;
      rd_q   <= 1'b0;
    end else if (rise && frame_q == 8'h00 && slot_q < EEP_ACK_SLOT) begin
      addr_q <= {addr_q[6:0], sda};
    end else if (ack_rise && frame_q == 8'h00) begin
      rd_q   <= addr_q[0];
    end
  end

  a_dev_sda_scl_low: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved SDA with SCL high");
  a_dev_ack_slot: assert property ((sda_dev_oe && $past(sda_dev_oe) && (frame_q == 8'h00 || !rd_q))
    |-> slot_q == EEP_ACK_SLOT) else $error("device drove SDA outside ack slot");
  a_rd_ack_release: assert property ((ack_rise && frame_q != 8'h00 && rd_q) |-> !sda_dev_oe)
    else $error("device held SDA in master ack slot");
  a_cs_match_ack: assert property ((ack_rise && frame_q == 8'h00 && cs_ok) |-> !sda)
    else $error("matching address not acked");
  a_cs_miss_nack: assert property ((ack_rise && frame_q == 8'h00 && !cs_ok) |-> sda)
    else $error("foreign address acked");
  a_hdr_addr_ack: assert property ((ack_rise && !rd_q && (frame_q == 8'h01 || frame_q == 8'h02)) |-> !sda)
    else $error("word address byte not acked");
  a_query_lock_ack: assert property ((ack_rise && frame_q == 8'h03 && !rd_q && addr_q[7:4] == EEP_ID_TYPE)
    |-> sda == ID_LOCKED) else $error("query ack does not follow lock state");
  a_scl_low_span: assert property (($fell(scl) && !$past(SYS_RST)) |-> !scl [*4])
    else $error("SCL low phase too short");
endmodule : eep_link_monitor

// ==== testbench/eep_seq_and_id_page_read_tb_top.sv ====
// Bench joining host and device ends over the link
`timescale 1ns/1ps
module eep_seq_and_id_page_read_tb_top
  import eep_pkg::*;
;
  logic        sys_clk;
  logic        sys_rst;
  logic        load_en;
  logic        load_id;
  logic [15:0] load_addr;
  logic [7:0]  load_data;
  logic [2:0]  cs_pins;
  logic        id_locked;
  logic        cmd_valid;
  logic        cmd_ready;
  eep_op_type  cmd_op;
  logic [2:0]  cmd_cs;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_count;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  logic        addr_nack;
  logic        lock_seen;
  int          mismatches;
  int          num_checks;
  logic [15:0] arr_list [6] = '{16'hFFFE, 16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h0003};
  logic [15:0] id_list  [4] = '{16'h0000, 16'h0001, 16'h007E, 16'h007F};

  eep_link_if link ();

  eep_dev_end eep_dev_end_i (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LOAD_EN(load_en), .LOAD_ID(load_id),
    .LOAD_ADDR(load_addr), .LOAD_DATA(load_data), .CHIP_SELECT_PIN_2(cs_pins[2]),
    .CHIP_SELECT_PIN_1(cs_pins[1]), .CHIP_SELECT_PIN_0(cs_pins[0]), .ID_LOCKED(id_locked), .LINK(link));

  eep_host_end eep_host_end_i (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_CS(cmd_cs), .CMD_ADDR(cmd_addr), .CMD_COUNT(cmd_count),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done), .ADDR_NACK(addr_nack),
    .ID_LOCKED_SEEN(lock_seen), .LINK(link));

  eep_link_monitor eep_link_monitor_i (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .scl(link.scl),
    .sda_host_oe(link.sda_host_oe), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda),
    .CHIP_SELECT_PIN_2(cs_pins[2]), .CHIP_SELECT_PIN_1(cs_pins[1]), .CHIP_SELECT_PIN_0(cs_pins[0]),
    .ID_LOCKED(id_locked));

  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Distinct contents for array and id page, so a wrong area shows
  function automatic logic [7:0] pat(input logic id, input logic [15:0] a);
    pat = id ? ({1'b1, a[6:0]} ^ 8'h33) : (a[7:0] ^ a[15:8] ^ 8'hC5);
  endfunction : pat

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic load(input logic id, input logic [15:0] a);
    @(negedge sys_clk);
    load_en   = 1'b1;
    load_id   = id;
    load_addr = a;
    load_data = pat(id, a);
    @(negedge sys_clk);
    load_en   = 1'b0;
  endtask : load

  // One command, every byte compared to the expected location
  task automatic run(input eep_op_type op, input logic [2:0] cs, input logic [15:0] a, input logic [7:0] n,
                     input logic [15:0] first, input logic [7:0] exp_n, input logic nack, input logic lock);
    logic [15:0] ptr;
    logic [7:0]  got;
    int          t;
    ptr = first;
    got = 8'h00;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_cs    = cs;
    cmd_addr  = a;
    cmd_count = n;
    // Hold the request until ready stands for the coming rising edge
    while (cmd_ready !== 1'b1) begin
      @(negedge sys_clk);
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (t = 0; t < 4000 && done !== 1'b1; t++) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) begin
        chk(rd_data, pat(op == OP_ID_READ, ptr));
        ptr = ptr + 16'h0001;
        got = got + 8'h01;
      end
    end
    chk({7'h00, done}, 8'h01);
    chk(got, exp_n);
    chk({7'h00, addr_nack}, {7'h00, nack});
    if (op == OP_LOCK_QUERY) begin
      chk({7'h00, lock_seen}, {7'h00, lock});
    end
  endtask : run

  task automatic t_wrap_read();
    run(OP_RAND_READ, 3'h2, 16'hFFFE, 8'h04, 16'hFFFE, 8'h04, 1'b0, 1'b0);
  endtask : t_wrap_read

  task automatic t_current_read();
    run(OP_CUR_READ, 3'h2, 16'h1234, 8'h02, 16'h0002, 8'h02, 1'b0, 1'b0);
  endtask : t_current_read

  // Upper address bits are junk; only the last two page bytes come back though five are asked
  task automatic t_id_read();
    run(OP_ID_READ, 3'h2, 16'hFC7E, 8'h05, 16'h007E, 8'h02, 1'b0, 1'b0);
    run(OP_ID_READ, 3'h2, 16'h0000, 8'h02, 16'h0000, 8'h02, 1'b0, 1'b0);
    run(OP_RAND_READ, 3'h2, 16'h0000, 8'h01, 16'h0000, 8'h01, 1'b0, 1'b0);
  endtask : t_id_read

  task automatic t_lock_query();
    run(OP_LOCK_QUERY, 3'h2, 16'h0000, 8'h01, 16'h0000, 8'h00, 1'b0, 1'b0);
    id_locked = 1'b1;
    run(OP_LOCK_QUERY, 3'h2, 16'h0000, 8'h01, 16'h0000, 8'h00, 1'b0, 1'b1);
  endtask : t_lock_query

  // Foreign select refused, then accepted once the straps match
  task automatic t_chip_select();
    run(OP_RAND_READ, 3'h5, 16'h0000, 8'h01, 16'h0000, 8'h00, 1'b1, 1'b0);
    cs_pins = 3'h5;
    run(OP_RAND_READ, 3'h5, 16'h0001, 8'h01, 16'h0001, 8'h01, 1'b0, 1'b0);
  endtask : t_chip_select

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well past the longest command sequence
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    sys_rst    = 1'b1;
    load_en    = 1'b0;
    load_id    = 1'b0;
    load_addr  = 16'h0000;
    load_data  = 8'h00;
    cs_pins    = 3'h2;
    id_locked  = 1'b0;
    cmd_valid  = 1'b0;
    cmd_op     = OP_CUR_READ;
    cmd_cs     = 3'h2;
    cmd_addr   = 16'h0000;
    cmd_count  = 8'h00;
    mismatches = 0;
    num_checks = 0;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    foreach (arr_list[i]) load(1'b0, arr_list[i]);
    foreach (id_list[i]) load(1'b1, id_list[i]);
    t_wrap_read();
    t_current_read();
    t_id_read();
    t_lock_query();
    t_chip_select();
    wrap_up();
  end
endmodule : eep_seq_and_id_page_read_tb_top
